// ===== verilog/bpl_loader.sv
// Binary packet loader: framing, checksum, handshake and rate control
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Rate command with store modifier: lower status report, switch rate, wait.
// - Wait about 100 ms after the status report before first acknowledge.
// - After the delay send one acknowledge 0x06 at the new rate.
// - Discard bytes until start character, then store the next 41 bytes.
// - After a full frame, check checksum and length before using data.
// - Checksum covers start character through end character; valid when zero.
// - Sum is 8 bits, carry out dropped; host picks checksum byte.
// - Failed check answers negative acknowledge 0x15, then hunt next frame.
// - Nothing carries over from one packet to the next.
// - No new packet taken during a memory write; reply after write ends.
// - Byte address shifted right to a 32-byte record address.
// - Valid packet is written, status polled to completion, then ACK, or NAK on write error or timeout.
// - Address field is 32 bits, byte address of first data byte.
// - End packet answered ACK if sum good, NAK if bad.
// - Bad sum never leaves binary mode; only valid end packet or reset.
// - After final ACK wait for transmitter idle, then return to base rate.
// - At base rate wait about 100 ms, then upper status and ready prompt.
// - After the start character, keep draining buffered data without pause.
// - Sustain 115,200 bit/s; two stop bits recommended in binary mode.
// - Rate command without modifier changes rate, stays in command mode.
module bpl_loader #(
    parameter int MS_CYCLES = bpl_pkg::CYC_PER_MS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire bpl_pkg::bpl_cmd_t cmd,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output bpl_pkg::bpl_byte_t tx_out,
    input wire logic tx_ready,
    input wire logic tx_idle,
    output bpl_pkg::bpl_rate_t rate,
    output logic binary_mode,
    output logic sts_lower,
    output logic sts_upper,
    output logic rdy_prompt,
    output bpl_pkg::bpl_mem_t mem_wr,
    input wire logic mem_done,
    input wire logic mem_err
);
    typedef enum logic [3:0] {
        S_IDLE, S_STS_LO, S_DLY_IN, S_HUNT, S_COLLECT, S_CHECK,
        S_MEM_WR, S_MEM_WAIT, S_SEND, S_DRAIN, S_DLY_OUT, S_STS_UP
    } bpl_state_t;

    bpl_state_t state_ff;
    bpl_pkg::bpl_rate_t rate_ff;
    bpl_pkg::bpl_rate_t pend_ff;
    bpl_pkg::bpl_byte_t tx_ff;
    bpl_pkg::bpl_mem_t mem_ff;
    logic [7:0] pkt_ff [bpl_pkg::PKT_LEN];
    logic [5:0] idx_ff;
    logic [4:0] k_ff;
    logic [7:0] sum_ff;
    logic end_ff;
    logic bin_ff;
    logic sts_lo_ff;
    logic sts_up_ff;
    logic rdy_ff;
    logic tmr_start;
    logic [15:0] tmr_ms;
    logic tmr_done;
    logic f_valid;
    logic [7:0] f_data;
    logic f_pop;
    logic [31:0] pkt_addr;
    logic [7:0] pkt_len;

    // 32-bit byte address
    // Byte address field, most significant byte first
    function automatic logic [31:0] addr_of(input logic [7:0] b0,
        input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
        addr_of = {b0, b1, b2, b3};
    endfunction : addr_of

    // ==========================================================
    // Output drive
    assign tx_out = tx_ff;
    assign rate = rate_ff;
    assign binary_mode = bin_ff;
    assign sts_lower = sts_lo_ff;
    assign sts_upper = sts_up_ff;
    assign rdy_prompt = rdy_ff;
    assign mem_wr = mem_ff;

    // fixed field order
    // Field decode of the stored frame
    assign pkt_addr = addr_of(pkt_ff[bpl_pkg::IDX_ADDR],
        pkt_ff[bpl_pkg::IDX_ADDR + 6'h01], pkt_ff[bpl_pkg::IDX_ADDR + 6'h02],
        pkt_ff[bpl_pkg::IDX_ADDR + 6'h03]);
    assign pkt_len = pkt_ff[bpl_pkg::IDX_LEN];

    // ==========================================================
    // Receive buffering
    bpl_fifo #(
        .WIDTH(8),
        .DEPTH(bpl_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(rx_valid),
        .in_data(rx_data),
        .in_ready(rx_ready),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(f_pop)
    );

    assign f_pop = f_valid && (state_ff == S_HUNT || state_ff == S_COLLECT);

    // ==========================================================
    // Delay timer
    bpl_timer #(
        .CYC_PER_MS(MS_CYCLES)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(tmr_start),
        .ms(tmr_ms),
        .done(tmr_done)
    );

    // settle delay
    // Timer loads: settle delays and write timeout
    always_comb begin
        tmr_start = 1'b0;
        tmr_ms = bpl_pkg::RATE_DELAY_MS;
        if (state_ff == S_STS_LO) begin
            tmr_start = 1'b1;
        end else if (state_ff == S_DRAIN && tx_idle) begin
            tmr_start = 1'b1;
        end else if (state_ff == S_MEM_WR && k_ff == bpl_pkg::DATA_LAST) begin
            tmr_start = 1'b1;
            tmr_ms = bpl_pkg::MEM_TIMEOUT_MS;
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= S_IDLE;
        end else begin
            unique case (state_ff)
                S_IDLE: begin
                    if (cmd_valid && cmd.store) begin
                        state_ff <= S_STS_LO;
                    end
                end
                S_STS_LO: state_ff <= S_DLY_IN;
                S_DLY_IN: begin
                    if (tmr_done) begin
                        state_ff <= S_SEND;
                    end
                end
                S_HUNT: begin
                    if (f_pop && f_data == bpl_pkg::CH_SOH) begin
                        state_ff <= S_COLLECT;
                    end
                end
                S_COLLECT: begin
                    if (f_pop && idx_ff == bpl_pkg::IDX_LAST) begin
                        state_ff <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (sum_ff != bpl_pkg::SUM_ZERO) begin
                        state_ff <= S_SEND;
                    end else if (pkt_len == bpl_pkg::LEN_DATA) begin
                        state_ff <= S_MEM_WR;
                    end else begin
                        state_ff <= S_SEND;
                    end
                end
                S_MEM_WR: begin
                    if (k_ff == bpl_pkg::DATA_LAST) begin
                        state_ff <= S_MEM_WAIT;
                    end
                end
                S_MEM_WAIT: begin
                    if (mem_done || tmr_done) begin
                        state_ff <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (tx_ready) begin
                        state_ff <= end_ff ? S_DRAIN : S_HUNT;
                    end
                end
                S_DRAIN: begin
                    if (tx_idle) begin
                        state_ff <= S_DLY_OUT;
                    end
                end
                S_DLY_OUT: begin
                    if (tmr_done) begin
                        state_ff <= S_STS_UP;
                    end
                end
                S_STS_UP: state_ff <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Bit rate and binary mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rate_ff <= bpl_pkg::RATE_BASE;
            pend_ff <= bpl_pkg::RATE_BASE;
            bin_ff <= 1'b0;
        end else if (state_ff == S_IDLE && cmd_valid) begin
            if (cmd.store) begin
                bin_ff <= 1'b1;
                pend_ff <= cmd.fast ? bpl_pkg::RATE_FAST : bpl_pkg::RATE_MID;
            end else begin
                rate_ff <= cmd.fast ? bpl_pkg::RATE_FAST : bpl_pkg::RATE_MID;
            end
        end else if (state_ff == S_STS_LO) begin
            rate_ff <= pend_ff;
        end else if (state_ff == S_DRAIN && tx_idle) begin
            rate_ff <= bpl_pkg::RATE_BASE;
        end else if (state_ff == S_STS_UP) begin
            bin_ff <= 1'b0;
        end
    end

    // Status report pulses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sts_lo_ff <= 1'b0;
            sts_up_ff <= 1'b0;
            rdy_ff <= 1'b0;
        end else begin
            sts_lo_ff <= (state_ff == S_IDLE) && cmd_valid && cmd.store;
            sts_up_ff <= (state_ff == S_DLY_OUT) && tmr_done;
            rdy_ff <= (state_ff == S_STS_UP);
        end
    end

    // ==========================================================
    // Frame capture and checksum
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idx_ff <= bpl_pkg::IDX_FIRST;
            sum_ff <= bpl_pkg::SUM_ZERO;
        end else if (state_ff == S_HUNT && f_pop) begin
            idx_ff <= bpl_pkg::IDX_FIRST;
            sum_ff <= f_data;
        end else if (state_ff == S_COLLECT && f_pop) begin
            idx_ff <= idx_ff + 6'h01;
            if (idx_ff <= bpl_pkg::IDX_EOT) begin
                sum_ff <= sum_ff + f_data;
            end
        end
    end

    // Packet storage, index addressed
    always_ff @(posedge clk) begin
        if (state_ff == S_COLLECT && f_pop) begin
            pkt_ff[idx_ff] <= f_data;
        end
    end

    // ==========================================================
    // Memory write stream
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            k_ff <= '0;
            mem_ff <= '0;
        end else if (state_ff == S_MEM_WR) begin
            k_ff <= k_ff + 5'h01;
            mem_ff.vld <= 1'b1;
            mem_ff.start <= (k_ff == '0);
            mem_ff.rec_addr <= pkt_addr >> bpl_pkg::REC_SHIFT;
            mem_ff.data <= pkt_ff[bpl_pkg::IDX_DATA + {1'b0, k_ff}];
        end else begin
            k_ff <= '0;
            mem_ff.vld <= 1'b0;
            mem_ff.start <= 1'b0;
        end
    end

    // ==========================================================
    // Reply character
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_ff <= '0;
            end_ff <= 1'b0;
        end else if (state_ff == S_DLY_IN && tmr_done) begin
            tx_ff <= {1'b1, bpl_pkg::CH_ACK};
            end_ff <= 1'b0;
        end else if (state_ff == S_CHECK) begin
            end_ff <= 1'b0;
            if (sum_ff != bpl_pkg::SUM_ZERO) begin
                tx_ff <= {1'b1, bpl_pkg::CH_NAK};
            end else if (pkt_len == bpl_pkg::LEN_END) begin
                tx_ff <= {1'b1, bpl_pkg::CH_ACK};
                end_ff <= 1'b1;
            end else if (pkt_len != bpl_pkg::LEN_DATA) begin
                tx_ff <= {1'b1, bpl_pkg::CH_NAK};
            end
        end else if (state_ff == S_MEM_WAIT) begin
            if (mem_done) begin
                tx_ff <= {1'b1, mem_err ? bpl_pkg::CH_NAK : bpl_pkg::CH_ACK};
            end else if (tmr_done) begin
                tx_ff <= {1'b1, bpl_pkg::CH_NAK};
            end
        end else if (state_ff == S_SEND && tx_ready) begin
            tx_ff.vld <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_reply_char;
        tx_ff.vld |-> (tx_ff.data == bpl_pkg::CH_ACK ||
            tx_ff.data == bpl_pkg::CH_NAK);
    endproperty
    a_reply_char: assert property (p_reply_char)
        else $error("reply is neither ACK nor NAK");

    property p_report_quiet;
        sts_lo_ff |-> bin_ff ##1 !tx_ff.vld [*8];
    endproperty
    a_report_quiet: assert property (p_report_quiet)
        else $error("acknowledge too soon after status report");

    property p_rate_after_report;
        sts_lo_ff |=> rate_ff == pend_ff;
    endproperty
    a_rate_after_report: assert property (p_rate_after_report)
        else $error("rate not switched after status report");

    property p_no_pop_in_write;
        (state_ff == S_MEM_WR || state_ff == S_MEM_WAIT) |-> !f_pop;
    endproperty
    a_no_pop_in_write: assert property (p_no_pop_in_write)
        else $error("byte taken during memory write");

    property p_bad_sum_nak;
        (state_ff == S_CHECK && sum_ff != bpl_pkg::SUM_ZERO)
            |=> tx_ff.vld && tx_ff.data == bpl_pkg::CH_NAK;
    endproperty
    a_bad_sum_nak: assert property (p_bad_sum_nak)
        else $error("bad checksum not answered with NAK");

    property p_rec_addr;
        mem_ff.start |-> mem_ff.rec_addr == (pkt_addr >> bpl_pkg::REC_SHIFT);
    endproperty
    a_rec_addr: assert property (p_rec_addr)
        else $error("record address not byte address shifted");

    property p_exit_binary;
        $fell(bin_ff) |-> rdy_ff && $past(sts_up_ff);
    endproperty
    a_exit_binary: assert property (p_exit_binary)
        else $error("binary mode left without end sequence");

    property p_base_after_idle;
        (bin_ff && $changed(rate_ff) && rate_ff == bpl_pkg::RATE_BASE)
            |-> $past(tx_idle) && !tx_ff.vld;
    endproperty
    a_base_after_idle: assert property (p_base_after_idle)
        else $error("base rate restored before transmitter idle");

    property p_collect_bound;
        state_ff == S_COLLECT |-> idx_ff <= bpl_pkg::IDX_LAST;
    endproperty
    a_collect_bound: assert property (p_collect_bound)
        else $error("frame index ran past 41");
endmodule : bpl_loader
`default_nettype wire

// ===== verilog/bpl_pkg.sv
// Shared constants and carrier types for the binary packet loader
package bpl_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    // Rate change settle time, milliseconds
    localparam logic [15:0] RATE_DELAY_MS = 16'h0064;
    // Memory write completion timeout, milliseconds
    localparam logic [15:0] MEM_TIMEOUT_MS = 16'h000A;

    // ==========================================================
    // Protocol characters and length codes
    localparam logic [7:0] CH_SOH = 8'h01;
    localparam logic [7:0] CH_ACK = 8'h06;
    localparam logic [7:0] CH_NAK = 8'h15;
    localparam logic [7:0] LEN_DATA = 8'h20;
    localparam logic [7:0] LEN_END = 8'h00;
    localparam logic [7:0] SUM_ZERO = 8'h00;

    // ==========================================================
    // Frame layout: SOH, len, addr[31:24..7:0], 32 data, sum, EOT, 2 pad
    localparam int PKT_LEN = 42;
    localparam logic [5:0] IDX_FIRST = 6'h01;
    localparam logic [5:0] IDX_LEN = 6'h01;
    localparam logic [5:0] IDX_ADDR = 6'h02;
    localparam logic [5:0] IDX_DATA = 6'h06;
    localparam logic [5:0] IDX_EOT = 6'h27;
    localparam logic [5:0] IDX_LAST = 6'h29;
    localparam logic [4:0] DATA_LAST = 5'h1F;
    localparam int REC_SHIFT = 5;
    localparam int FIFO_DEPTH = 8;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {RATE_BASE, RATE_MID, RATE_FAST} bpl_rate_t;

    typedef struct packed {
        logic fast;
        logic store;
    } bpl_cmd_t;

    typedef struct packed {
        logic vld;
        logic [7:0] data;
    } bpl_byte_t;

    typedef struct packed {
        logic vld;
        logic start;
        logic [31:0] rec_addr;
        logic [7:0] data;
    } bpl_mem_t;

endpackage : bpl_pkg

// ===== verilog/bpl_fifo.sv
// Receive byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module bpl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [PW:0] cnt_ff;
    logic [PW:0] nxt_cnt;
    logic ready_ff;
    logic valid_ff;
    logic push;
    logic pop;

    // ==========================================================
    // Handshakes
    assign push = in_valid && ready_ff;
    assign pop = out_ready && valid_ff;
    assign in_ready = ready_ff;
    assign out_valid = valid_ff;
    assign out_data = mem_ff[rd_ff];
    assign nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    // Pointers, count and flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            ready_ff <= 1'b1;
            valid_ff <= 1'b0;
        end else begin
            wr_ff <= wr_ff + PW'(push);
            rd_ff <= rd_ff + PW'(pop);
            cnt_ff <= nxt_cnt;
            ready_ff <= (nxt_cnt != CNT_FULL);
            valid_ff <= (nxt_cnt != '0);
        end
    end
endmodule : bpl_fifo
`default_nettype wire

// ===== verilog/bpl_timer.sv
// Millisecond delay timer driven by a divider enable pulse
`timescale 1ns/1ps
`default_nettype none
module bpl_timer #(
    parameter int CYC_PER_MS = bpl_pkg::CYC_PER_MS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [15:0] ms,
    output logic done
);
    logic [31:0] div_ff;
    logic ms_tick_ff;
    logic [15:0] left_ff;
    logic run_ff;
    logic done_ff;

    assign done = done_ff;

    // Divider producing one-cycle millisecond enable
    always_ff @(posedge clk) begin
        if (sys_rst || start) begin
            div_ff <= '0;
            ms_tick_ff <= 1'b0;
        end else if (div_ff == 32'(CYC_PER_MS - 1)) begin
            div_ff <= '0;
            ms_tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 32'h0000_0001;
            ms_tick_ff <= 1'b0;
        end
    end

    // Millisecond down counter with done pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            left_ff <= '0;
            run_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (start) begin
            left_ff <= ms;
            run_ff <= 1'b1;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (run_ff && ms_tick_ff) begin
                left_ff <= left_ff - 16'h0001;
                if (left_ff <= 16'h0001) begin
                    run_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end
endmodule : bpl_timer
`default_nettype wire

// ===== verification/bpl_far_model.sv
// Far side model: reply transmitter and memory status poll
`timescale 1ns/1ps
`default_nettype none
module bpl_far_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire bpl_pkg::bpl_byte_t tx_out,
    input wire bpl_pkg::bpl_mem_t mem_wr,
    output logic tx_ready,
    output logic tx_idle,
    output logic mem_done,
    output logic mem_err
);
    // ==========================================================
    // Memory write completion
    logic [5:0] wr_cnt_ff;
    logic [3:0] wait_ff;
    logic [3:0] shift_ff;
    logic [31:0] rec_ff;
    always_ff @(posedge clk) begin
        if (sys_rst || wr_cnt_ff == 6'h20) begin
            wr_cnt_ff <= 6'h00;
        end else if (mem_wr.vld) begin
            wr_cnt_ff <= wr_cnt_ff + 6'h01;
        end
        if (sys_rst) begin
            wait_ff <= 4'h0;
        end else if (wr_cnt_ff == 6'h20) begin
            wait_ff <= 4'h9;
        end else if (wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end
        if (sys_rst) begin
            rec_ff <= 32'h0000_0000;
        end else if (mem_wr.vld && mem_wr.start) begin
            rec_ff <= mem_wr.rec_addr;
        end
    end
    assign mem_done = (wait_ff == 4'h1);
    // Record one always fails, to provoke a NAK
    assign mem_err = (rec_ff == 32'h0000_0001);
    // ==========================================================
    // Transmitter: busy for a few cycles after each character
    // shift register busy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_ff <= 4'h0;
        end else if (tx_out.vld && tx_ready) begin
            shift_ff <= 4'h5;
        end else if (shift_ff != 4'h0) begin
            shift_ff <= shift_ff - 4'h1;
        end
    end
    assign tx_ready = (shift_ff == 4'h0);
    assign tx_idle = (shift_ff == 4'h0);
endmodule : bpl_far_model
`default_nettype wire

// ===== verification/tb_bpl_loader.sv
// Testbench for the binary packet loader
`timescale 1ns/1ps
`default_nettype none
module tb_bpl_loader;
    // ==========================================================
    // Signals
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    bpl_pkg::bpl_cmd_t cmd = 2'b00;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_ready, tx_ready, tx_idle, binary_mode;
    logic sts_lower, sts_upper, rdy_prompt, mem_done, mem_err;
    bpl_pkg::bpl_byte_t tx_out;
    bpl_pkg::bpl_rate_t rate;
    bpl_pkg::bpl_mem_t mem_wr;
    int err_count = 0;
    int check_count = 0;
    int n;
    logic [31:0] got_rec = 32'h0000_0000;
    logic got_low = 1'b0;
    logic got_up = 1'b0;
    logic got_rdy = 1'b0;
    logic [7:0] got_dat = 8'h00;
    logic [5:0] got_wrn = 6'h00;
    always #25 clk = ~clk;
    // Pulse and record address capture
    always @(posedge clk) begin
        if (sts_lower === 1'b1) got_low <= 1'b1;
        if (sts_upper === 1'b1) got_up <= 1'b1;
        if (rdy_prompt === 1'b1) got_rdy <= 1'b1;
        if (mem_wr.vld === 1'b1 && mem_wr.start === 1'b1) begin
            got_rec <= mem_wr.rec_addr;
        end
        if (mem_wr.vld === 1'b1) begin
            got_wrn <= (mem_wr.start === 1'b1) ? 6'h01 : got_wrn + 6'h01;
            got_dat <= mem_wr.data;
        end
    end
    // ==========================================================
    // Instances
    bpl_loader #(.MS_CYCLES(4)) bpl_loader_i (.clk(clk),
        .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_out(tx_out), .tx_ready(tx_ready), .tx_idle(tx_idle),
        .rate(rate), .binary_mode(binary_mode), .sts_lower(sts_lower),
        .sts_upper(sts_upper), .rdy_prompt(rdy_prompt),
        .mem_wr(mem_wr), .mem_done(mem_done), .mem_err(mem_err));
    bpl_far_model bpl_far_model_i (.clk(clk), .sys_rst(sys_rst),
        .tx_out(tx_out), .mem_wr(mem_wr), .tx_ready(tx_ready),
        .tx_idle(tx_idle), .mem_done(mem_done), .mem_err(mem_err));
    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : chk
    task automatic put_byte(input logic [7:0] b);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = b;
        while (rx_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask : put_byte
    task automatic send_frame(input logic [7:0] len,
                              input logic [31:0] adr, input logic bad);
        logic [7:0] f [42];
        logic [7:0] s;
        f[0] = bpl_pkg::CH_SOH;
        f[1] = len;
        for (int i = 0; i < 4; i++) f[2+i] = adr[31-8*i -: 8];
        for (int i = 0; i < 32; i++) f[6+i] = 8'(i * 7 + 2);
        f[39] = 8'h04;
        f[40] = 8'h00;
        f[41] = 8'h00;
        s = 8'h00;
        for (int i = 0; i < 40; i++) if (i != 38) s = s + f[i];
        f[38] = 8'h00 - s + {7'h00, bad};
        for (int i = 0; i < 42; i++) put_byte(f[i]);
        @(negedge clk);
        rx_valid = 1'b0;
    endtask : send_frame
    task automatic reply(input logic [7:0] e);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(tx_out.vld === 1'b1 && tx_ready === 1'b1)
                   && n < 5000);
        chk("reply valid", 32'h0000_0001, 32'(tx_out.vld));
        chk("reply", {24'h00_0000, e}, {24'h00_0000, tx_out.data});
    endtask : reply
    task automatic give_cmd(input logic f, input logic s);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd.fast = f;
        cmd.store = s;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : give_cmd
    // ==========================================================
    // Scenarios
    task automatic t_rate_only();
        give_cmd(1'b0, 1'b0);
        repeat (3) @(negedge clk);
        chk("rate", 32'h0000_0001, 32'(rate));
        chk("binary", 32'h0000_0000, 32'(binary_mode));
        chk("lower", 32'h0000_0000, 32'(got_low));
        chk("rx ready", 32'h0000_0001, 32'(rx_ready));
    endtask : t_rate_only
    task automatic t_enter();
        give_cmd(1'b1, 1'b1);
        reply(bpl_pkg::CH_ACK);
        chk("lower", 32'h0000_0001, 32'(got_low));
        chk("rate", 32'h0000_0002, 32'(rate));
        chk("delay", 32'h0000_0001, 32'(n >= 396 && n <= 410));
    endtask : t_enter
    task automatic t_data();
        put_byte(8'h55);
        put_byte(8'hAA);
        send_frame(bpl_pkg::LEN_DATA, 32'h0000_0460, 1'b0);
        reply(bpl_pkg::CH_ACK);
        chk("record", 32'h0000_0023, got_rec);
        chk("writes", 32'h0000_0020, 32'(got_wrn));
        chk("last data", 32'h0000_00DB, 32'(got_dat));
    endtask : t_data
    task automatic t_bad();
        send_frame(bpl_pkg::LEN_DATA, 32'h0000_0020, 1'b1);
        reply(bpl_pkg::CH_NAK);
        send_frame(bpl_pkg::LEN_DATA, 32'h0000_0020, 1'b0);
        reply(bpl_pkg::CH_NAK);
        send_frame(8'h10, 32'h0000_0020, 1'b0);
        reply(bpl_pkg::CH_NAK);
        send_frame(bpl_pkg::LEN_END, 32'h0000_0000, 1'b1);
        reply(bpl_pkg::CH_NAK);
        chk("binary", 32'h0000_0001, 32'(binary_mode));
    endtask : t_bad
    task automatic t_end();
        send_frame(bpl_pkg::LEN_END, 32'h0000_0000, 1'b0);
        reply(bpl_pkg::CH_ACK);
        n = 0;
        while (got_rdy !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk("rate", 32'h0000_0000, 32'(rate));
        chk("upper", 32'h0000_0001, 32'(got_up));
        chk("ready", 32'h0000_0001, 32'(got_rdy));
        chk("wait", 32'h0000_0001, 32'(n >= 398 && n < 430));
        chk("binary", 32'h0000_0000, 32'(binary_mode));
    endtask : t_end
    task automatic t_mid();
        give_cmd(1'b0, 1'b1);
        reply(bpl_pkg::CH_ACK);
        chk("rate", 32'h0000_0001, 32'(rate));
        give_cmd(1'b1, 1'b0);
        repeat (3) @(negedge clk);
        chk("rate", 32'h0000_0001, 32'(rate));
        chk("binary", 32'h0000_0001, 32'(binary_mode));
    endtask : t_mid
    // ==========================================================
    // Verdict
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        t_rate_only();
        t_enter();
        t_data();
        t_bad();
        t_end();
        t_mid();
        results();
    end
    // Watchdog
    initial begin
        #(50 * 20000);
        err_count++;
        results();
    end
endmodule : tb_bpl_loader
`default_nettype wire
